// ---- ddsc_pkg.sv ----
package ddsc_pkg;
    // ****************************************
    // register map and field layout
    // ****************************************
    localparam logic [5:0] ADDR_OC_LOW   = 6'h10;
    localparam logic [5:0] ADDR_ULD_LOW  = 6'h11;
    localparam logic [5:0] ADDR_FAULT_HI = 6'h12;
    localparam logic [5:0] ADDR_CONFIG   = 6'h3f;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam int DRV_N      = 11;
    localparam int LOW_N      = 6;
    localparam int EC_IDX     = 10;
    localparam int LOW_TOP    = 15;
    localparam int HI_TOP     = 13;
    localparam int BIT_UV     = 3;
    localparam int BIT_OV     = 2;
    localparam int BIT_BELOW  = 1;
    localparam int BIT_ABOVE  = 0;
    localparam int CFG_BOOST  = 15;
    localparam int CFG_FINE   = 14;
    localparam int CFG_HS1    = 5;
    localparam int CFG_LS1    = 4;
    localparam int CFG_TW     = 3;
    localparam int CFG_GULD   = 1;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ      = 10;
    localparam int EC_FILT_US   = 32;
    localparam int EC_FILT_CYC  = EC_FILT_US * CLK_MHZ;
    localparam int ULD_FILT_US  = 100;
    localparam int ULD_FILT_CYC = ULD_FILT_US * CLK_MHZ;
    localparam int RECOV_US     = 1000;
    localparam int RECOV_CYC    = RECOV_US * CLK_MHZ;

    typedef struct packed {
        logic boost_en;
        logic fine_res;
        logic hs1_mask;
        logic ls1_mask;
        logic tw_mask;
        logic uld_gmask;
    } ddsc_cfg_s;
endpackage

// ---- ddsc_filter.sv ----
`timescale 1ns/1ns
module ddsc_filter
    import ddsc_pkg::*;
#(
    parameter int CYC = 320
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic LVL,
    output logic      Q
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LIM = CW'(CYC - 1);

    logic [CW-1:0] cnt;

    if (CYC < 1) begin : g_chk
        $error("filter length must be at least one cycle");
    end

    // qualified level only after CYC consecutive cycles high
    always_ff @(posedge CLK) begin
        if (RST || !LVL) begin
            cnt <= '0;
            Q   <= 1'b0;
        end else if (cnt == LIM) begin
            Q <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

// ---- ddsc_top.sv ----
// Notes on behaviour
// RULE1: word 11h holds six underload flags, outputs 1-6, D15..D10; rest zero.
// RULE2: read/clear flags return value then clear, unless condition still present.
// RULE3: underload checked only while on; set after low current lasts filter time.
// RULE4: any output underload also raises the global underload bit.
// RULE5: global underload mask suppresses global underload bit; per-output flags stay.
// RULE6: word 12h: OC/ULD pairs outputs 7-10 D13..D6, undervoltage D3, overvoltage D2.
// RULE7: mirror variant adds feedback OC D5, ULD D4, below D1, above D0.
// RULE8: overcurrent sets driver flag, switches it off, sets global fault bit.
// RULE9: recovery enabled: output re-enabled after the selected recovery delay.
// RULE10: recovery disabled: host clears flag and re-enables output itself.
// RULE11: undervoltage switches all outputs off at once and sets its flag.
// RULE12: overvoltage switches all outputs off at once and sets its flag.
// RULE13: latch bit clear: outputs return automatically once supply recovers.
// RULE14: latch bit set: host clears supply flag before outputs return.
// RULE15: mirror mode reports feedback deviation only after it persists filter time.
// RULE16: below/above code: 00 in range, 01 above, 10 below, 11 unused.
// RULE17: regulation flags do not latch; they follow the filtered comparators.
// RULE18: regulation flags never feed the global fault bit.
// RULE19: config 3Fh: boost D15, fine D14, masks D5 D4 D3 D1, reset zero.
// RULE20: boost enable and boost select together run PWM at higher frequencies.
// RULE21: fine resolution bit widens PWM duty from seven to nine bits.
// RULE22: thermal warning mask suppresses the global thermal warning bit.
// RULE23: unused bits read zero and ignore writes.
`timescale 1ns/1ns
module ddsc_top
    import ddsc_pkg::*;
#(
    parameter int RECOV_BASE_CYC = RECOV_CYC,
    parameter bit EC_OPTION      = 1'b1
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             RD_STB,
    input  wire logic             WR_STB,
    input  wire logic [5:0]       ADDR,
    input  wire logic [15:0]      WDATA,
    output logic      [15:0]      RDATA,
    input  wire logic [DRV_N-1:0] ON_REQ,
    input  wire logic [DRV_N-1:0] OC_DET,
    input  wire logic [DRV_N-1:0] UC_DET,
    input  wire logic             VS_UV_DET,
    input  wire logic             VS_OV_DET,
    input  wire logic             OC_RECOV_EN,
    input  wire logic [1:0]       RECOV_DELAY_SEL,
    input  wire logic             SUPPLY_LATCH,
    input  wire logic             EC_MODE,
    input  wire logic             EC_FB_LOW,
    input  wire logic             EC_FB_HIGH,
    input  wire logic             THERM_WARN_DET,
    input  wire logic             PWM_BOOST_SEL,
    output logic      [DRV_N-1:0] OUT_EN,
    output logic                  GLOBAL_ULD,
    output logic                  GLOBAL_FAULT,
    output logic                  THERMAL_WARNING,
    output logic                  PWM_BOOST_ACTIVE,
    output logic                  PWM_FINE_RES
);
    localparam int RCW = $clog2(RECOV_BASE_CYC * 8 + 1);
    localparam int SYN = 2 * DRV_N + 5;

    if (RECOV_BASE_CYC < 1) begin : g_chk
        $error("recovery base delay must be at least one cycle");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [SYN-1:0]   sync_a, sync_b;
    logic [DRV_N-1:0] oc_s, uc_s;
    logic             uv_s, ov_s, lo_s, hi_s, tw_s;

    always_ff @(posedge CLK) begin
        if (RST) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {OC_DET, UC_DET, VS_UV_DET, VS_OV_DET,
                       EC_FB_LOW, EC_FB_HIGH, THERM_WARN_DET};
            sync_b <= sync_a;
        end
    end

    // the feedback driver does not exist without the mirror option
    localparam logic [DRV_N-1:0] DRV_MASK =
        EC_OPTION ? {DRV_N{1'b1}} : {1'b0, {(DRV_N-1){1'b1}}};

    assign oc_s = sync_b[SYN-1 -: DRV_N] & DRV_MASK;
    assign uc_s = sync_b[SYN-1-DRV_N -: DRV_N] & DRV_MASK;
    assign uv_s = sync_b[4];
    assign ov_s = sync_b[3];
    assign lo_s = sync_b[2];
    assign hi_s = sync_b[1];
    assign tw_s = sync_b[0];

    // ****************************************
    // register port and clear-on-read
    // ****************************************
    ddsc_cfg_s        cfg;
    logic [DRV_N-1:0] oc_flag, uld_flag;
    logic             uv_flag, ov_flag, below, above;
    logic             rd_oc, rd_uld, rd_hi;
    logic [DRV_N-1:0] clr_oc, clr_uld;
    logic [15:0]      word_oc, word_uld, word_hi, word_cfg;

    assign rd_oc  = RD_STB && (ADDR == ADDR_OC_LOW);
    assign rd_uld = RD_STB && (ADDR == ADDR_ULD_LOW);
    assign rd_hi  = RD_STB && (ADDR == ADDR_FAULT_HI);
    assign clr_oc  = {{(DRV_N-LOW_N){rd_hi}}, {LOW_N{rd_oc}}};
    assign clr_uld = {{(DRV_N-LOW_N){rd_hi}}, {LOW_N{rd_uld}}};

    // flag i sits at bit top-i for the low group, pairs for the high group
    always_comb begin
        word_oc  = RST_WORD;
        word_uld = RST_WORD;
        word_hi  = RST_WORD;
        for (int i = 0; i < LOW_N; i++) begin
            word_oc[LOW_TOP-i]  = oc_flag[i];
            word_uld[LOW_TOP-i] = uld_flag[i];  // RULE1
        end
        for (int j = 0; j < DRV_N-LOW_N; j++) begin
            word_hi[HI_TOP-2*j]   = oc_flag[LOW_N+j];  // RULE6 RULE7
            word_hi[HI_TOP-2*j-1] = uld_flag[LOW_N+j];  // RULE6 RULE7
        end
        word_hi[BIT_UV]    = uv_flag;  // RULE6
        word_hi[BIT_OV]    = ov_flag;  // RULE6
        word_hi[BIT_BELOW] = below & EC_OPTION;  // RULE7
        word_hi[BIT_ABOVE] = above & EC_OPTION;  // RULE7
        word_cfg = RST_WORD;
        word_cfg[CFG_BOOST] = cfg.boost_en;
        word_cfg[CFG_FINE]  = cfg.fine_res;
        word_cfg[CFG_HS1]   = cfg.hs1_mask;
        word_cfg[CFG_LS1]   = cfg.ls1_mask;
        word_cfg[CFG_TW]    = cfg.tw_mask;
        word_cfg[CFG_GULD]  = cfg.uld_gmask;
    end

    // unmapped addresses read zero; reads capture before the clear lands
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= RST_WORD;
        end else if (RD_STB) begin
            case (ADDR)
                ADDR_OC_LOW:   RDATA <= word_oc;
                ADDR_ULD_LOW:  RDATA <= word_uld;
                ADDR_FAULT_HI: RDATA <= word_hi;
                ADDR_CONFIG:   RDATA <= word_cfg;
                default:       RDATA <= RST_WORD;  // RULE23
            endcase
        end
    end

    // only the defined config bits store; others are dropped
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg <= '0;  // RULE19
        end else if (WR_STB && (ADDR == ADDR_CONFIG)) begin
            cfg.boost_en  <= WDATA[CFG_BOOST];  // RULE19 RULE23
            cfg.fine_res  <= WDATA[CFG_FINE];
            cfg.hs1_mask  <= WDATA[CFG_HS1];
            cfg.ls1_mask  <= WDATA[CFG_LS1];
            cfg.tw_mask   <= WDATA[CFG_TW];
            cfg.uld_gmask <= WDATA[CFG_GULD];
        end
    end

    // ****************************************
    // overcurrent and recovery
    // ****************************************
    function automatic logic [RCW-1:0] recov_lim(input logic [1:0] sel);
        logic [RCW-1:0] base;
        base = RCW'(RECOV_BASE_CYC);
        return (base << sel) - 1'b1;
    endfunction

    logic [DRV_N-1:0] oc_off;
    logic [RCW-1:0]   rcnt [DRV_N];

    always_ff @(posedge CLK) begin
        if (RST) begin
            oc_flag <= '0;
            oc_off  <= '0;
            for (int i = 0; i < DRV_N; i++) begin
                rcnt[i] <= '0;
            end
        end else begin
            // a live event wins over the clear of the same cycle
            oc_flag <= (oc_flag & ~clr_oc) | oc_s;  // RULE2 RULE8
            for (int i = 0; i < DRV_N; i++) begin
                if (oc_s[i]) begin
                    oc_off[i] <= 1'b1;  // RULE8
                    rcnt[i]   <= '0;
                end else if (oc_off[i] && OC_RECOV_EN) begin
                    if (rcnt[i] == recov_lim(RECOV_DELAY_SEL)) begin
                        oc_off[i] <= 1'b0;  // RULE9
                    end else begin
                        rcnt[i] <= rcnt[i] + 1'b1;
                    end
                end else if (oc_off[i] && !oc_flag[i] && !ON_REQ[i]) begin
                    // host must clear the flag and request the output anew
                    oc_off[i] <= 1'b0;  // RULE10
                end
            end
        end
    end

    // ****************************************
    // supply faults and output stage enables
    // ****************************************
    logic supply_block;

    assign supply_block = uv_s || ov_s ||
                          (SUPPLY_LATCH && (uv_flag || ov_flag));  // RULE13 RULE14

    always_ff @(posedge CLK) begin
        if (RST) begin
            uv_flag <= 1'b0;
            ov_flag <= 1'b0;
        end else begin
            uv_flag <= (uv_flag & ~rd_hi) | uv_s;  // RULE2 RULE11
            ov_flag <= (ov_flag & ~rd_hi) | ov_s;  // RULE2 RULE12
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            OUT_EN <= '0;
        end else begin
            OUT_EN <= ON_REQ & DRV_MASK & ~oc_off & ~oc_s &
                      ~{DRV_N{supply_block}};  // RULE8 RULE11 RULE12
        end
    end

    // ****************************************
    // underload detection
    // ****************************************
    logic [DRV_N-1:0] uld_in, uld_q;

    always_comb begin
        uld_in = uc_s & OUT_EN;  // RULE3
        uld_in[0] = uld_in[0] & ~cfg.hs1_mask;
        uld_in[1] = uld_in[1] & ~cfg.ls1_mask;
    end

    for (genvar g = 0; g < DRV_N; g++) begin : g_uld
        ddsc_filter #(
            .CYC (ULD_FILT_CYC)
        ) u_filt (
            .CLK (CLK),
            .RST (RST),
            .LVL (uld_in[g]),
            .Q   (uld_q[g])
        );  // RULE3
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            uld_flag <= '0;
        end else begin
            uld_flag <= (uld_flag & ~clr_uld) | uld_q;  // RULE2 RULE3
        end
    end

    // ****************************************
    // mirror regulation monitor
    // ****************************************
    logic lo_in, hi_in;

    // below has priority so the unused code never shows
    assign lo_in = EC_OPTION && EC_MODE && lo_s;  // RULE16
    assign hi_in = EC_OPTION && EC_MODE && hi_s && !lo_s;  // RULE16

    ddsc_filter #(
        .CYC (EC_FILT_CYC)
    ) u_below (
        .CLK (CLK),
        .RST (RST),
        .LVL (lo_in),
        .Q   (below)
    );  // RULE15 RULE17

    ddsc_filter #(
        .CYC (EC_FILT_CYC)
    ) u_above (
        .CLK (CLK),
        .RST (RST),
        .LVL (hi_in),
        .Q   (above)
    );  // RULE15 RULE17

    // ****************************************
    // global bits and pwm options
    // ****************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            GLOBAL_ULD       <= 1'b0;
            GLOBAL_FAULT     <= 1'b0;
            THERMAL_WARNING  <= 1'b0;
            PWM_BOOST_ACTIVE <= 1'b0;
            PWM_FINE_RES     <= 1'b0;
        end else begin
            GLOBAL_ULD       <= (|uld_flag) && !cfg.uld_gmask;  // RULE4 RULE5
            // regulation flags deliberately left out of the fault sum
            GLOBAL_FAULT     <= (|oc_flag) || uv_flag || ov_flag;  // RULE8 RULE18
            THERMAL_WARNING  <= tw_s && !cfg.tw_mask;  // RULE22
            PWM_BOOST_ACTIVE <= cfg.boost_en && PWM_BOOST_SEL;  // RULE20
            PWM_FINE_RES     <= cfg.fine_res;  // RULE21
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_uv_shutoff: assert property (uv_s |=> OUT_EN == '0)  // RULE11
        else $error("outputs not off after undervoltage");
    a_ov_shutoff: assert property (ov_s |=> (OUT_EN == '0) && ov_flag)  // RULE12
        else $error("overvoltage did not shut off and flag");
    a_oc_shutoff: assert property (oc_s[0] |=> !OUT_EN[0] ##1 GLOBAL_FAULT)  // RULE8
        else $error("overcurrent did not switch off or set global");
    a_read_clear: assert property (rd_hi && !uv_s ##1 !uv_s |-> !uv_flag)  // RULE2
        else $error("undervoltage flag not cleared by read");
    a_gmask_uld: assert property (cfg.uld_gmask |=> !GLOBAL_ULD)  // RULE5
        else $error("global underload set while masked");
    a_ec_code: assert property (!(below && above))  // RULE16
        else $error("unused regulation code shown");
    a_ec_filter: assert property ($rose(below) |-> $past(lo_in, 2))  // RULE15
        else $error("below flag without persistent cause");
    a_uld_word: assert property (rd_uld |=> RDATA[9:0] == 10'h000)  // RULE1
        else $error("underload word low bits not zero");
    a_tw_mask: assert property (cfg.tw_mask |=> !THERMAL_WARNING)  // RULE22
        else $error("thermal warning shown while masked");
    a_latch_hold: assert property (SUPPLY_LATCH && uv_flag |=> OUT_EN == '0)  // RULE14
        else $error("outputs returned with latched supply fault");
endmodule

// ---- ddsc_host.sv ----
`timescale 1ns/1ns
module ddsc_host (
    input  wire logic        CLK,
    input  wire logic [15:0] RDATA,
    output logic             RD_STB,
    output logic             WR_STB,
    output logic [5:0]       ADDR,
    output logic [15:0]      WDATA
);
    // ****************************************
    // host side of the register strobe port
    // ****************************************
    initial begin
        RD_STB = 1'b0;
        WR_STB = 1'b0;
        ADDR   = 6'h00;
        WDATA  = 16'h0000;
    end
    // a read is the only way to clear latched flags; latched outputs wait on it
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge CLK);
        RD_STB <= 1'b1;
        ADDR   <= a;
        @(posedge CLK);
        RD_STB <= 1'b0;
        @(negedge CLK);
        d = RDATA;
    endtask
    // data is scrambled once taken so a stale value never passes
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge CLK);
        WR_STB <= 1'b1;
        ADDR   <= a;
        WDATA  <= v;
        @(posedge CLK);
        WR_STB <= 1'b0;
        WDATA  <= ~v;
    endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb
    import ddsc_pkg::*;
;
    // ****************************************
    // signals and instances
    // ****************************************
    logic             CLK, RST, RD_STB, WR_STB;
    logic [5:0]       ADDR;
    logic [15:0]      WDATA, RDATA, out_w;
    logic [DRV_N-1:0] ON_REQ, OC_DET, UC_DET, OUT_EN;
    logic             VS_UV_DET, VS_OV_DET, OC_RECOV_EN, SUPPLY_LATCH;
    logic [1:0]       RECOV_DELAY_SEL;
    logic             EC_MODE, EC_FB_LOW, EC_FB_HIGH, THERM_WARN_DET;
    logic             PWM_BOOST_SEL, GLOBAL_ULD, GLOBAL_FAULT;
    logic             THERMAL_WARNING, PWM_BOOST_ACTIVE, PWM_FINE_RES;
    int               n_fail = 0;
    int               n_compared = 0;
    assign out_w = {5'h00, OUT_EN};

    ddsc_host u_ddsc_host (.CLK(CLK), .RDATA(RDATA), .RD_STB(RD_STB),
        .WR_STB(WR_STB), .ADDR(ADDR), .WDATA(WDATA));
    // short recovery base keeps the delay test fast
    ddsc_top #(.RECOV_BASE_CYC(4), .EC_OPTION(1'b1)) u_ddsc_top (
        .CLK(CLK), .RST(RST), .RD_STB(RD_STB), .WR_STB(WR_STB),
        .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .ON_REQ(ON_REQ),
        .OC_DET(OC_DET), .UC_DET(UC_DET), .VS_UV_DET(VS_UV_DET),
        .VS_OV_DET(VS_OV_DET), .OC_RECOV_EN(OC_RECOV_EN),
        .RECOV_DELAY_SEL(RECOV_DELAY_SEL), .SUPPLY_LATCH(SUPPLY_LATCH),
        .EC_MODE(EC_MODE), .EC_FB_LOW(EC_FB_LOW), .EC_FB_HIGH(EC_FB_HIGH),
        .THERM_WARN_DET(THERM_WARN_DET), .PWM_BOOST_SEL(PWM_BOOST_SEL),
        .OUT_EN(OUT_EN), .GLOBAL_ULD(GLOBAL_ULD),
        .GLOBAL_FAULT(GLOBAL_FAULT), .THERMAL_WARNING(THERMAL_WARNING),
        .PWM_BOOST_ACTIVE(PWM_BOOST_ACTIVE), .PWM_FINE_RES(PWM_FINE_RES));

    // ****************************************
    // helpers
    // ****************************************
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic rdc(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_ddsc_host.rd(a, d);
        chk($sformatf("word %h", a), e, d);
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic timed_out;
        $display("[ERR] wait limit expected done seen stuck");
        n_fail++;
        end_of_test;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdc(ADDR_ULD_LOW, RST_WORD);
        rdc(ADDR_FAULT_HI, RST_WORD);
        rdc(ADDR_CONFIG, RST_WORD);
        @(posedge CLK);
        ON_REQ <= 11'h7ff;
        edges(3);
        @(negedge CLK);
        chk("out_en", 16'h07ff, out_w);
    endtask
    task automatic t_config;
        @(posedge CLK);
        THERM_WARN_DET <= 1'b1;
        PWM_BOOST_SEL  <= 1'b1;
        u_ddsc_host.wr(ADDR_CONFIG, 16'hffff);
        rdc(ADDR_CONFIG, 16'hc03a);
        edges(2);
        @(negedge CLK);
        chk1("boost", 1'b1, PWM_BOOST_ACTIVE);
        chk1("fine", 1'b1, PWM_FINE_RES);
        chk1("therm", 1'b0, THERMAL_WARNING);
        @(posedge CLK);
        PWM_BOOST_SEL <= 1'b0;
        edges(3);
        @(negedge CLK);
        chk1("boost", 1'b0, PWM_BOOST_ACTIVE);
        u_ddsc_host.wr(ADDR_ULD_LOW, 16'hffff);
        rdc(ADDR_ULD_LOW, 16'h0000);
        rdc(6'h20, 16'h0000);
        u_ddsc_host.wr(ADDR_CONFIG, 16'h0000);
        edges(3);
        @(negedge CLK);
        chk1("therm", 1'b1, THERMAL_WARNING);
        chk1("fine", 1'b0, PWM_FINE_RES);
        @(posedge CLK);
        THERM_WARN_DET <= 1'b0;
    endtask
    task automatic t_overcurrent;
        int n;
        @(posedge CLK);
        OC_DET[6] <= 1'b1;
        edges(4);
        @(negedge CLK);
        chk("out_en", 16'h07bf, out_w);
        chk1("fault", 1'b1, GLOBAL_FAULT);
        @(posedge CLK);
        OC_DET[6] <= 1'b0;
        edges(3);
        rdc(ADDR_FAULT_HI, 16'h2000);
        rdc(ADDR_FAULT_HI, 16'h0000);
        chk("out_en", 16'h07bf, out_w);
        @(posedge CLK);
        ON_REQ[6] <= 1'b0;
        @(posedge CLK);
        ON_REQ[6] <= 1'b1;
        edges(3);
        @(negedge CLK);
        chk("out_en", 16'h07ff, out_w);
        chk1("fault", 1'b0, GLOBAL_FAULT);
        @(posedge CLK);
        OC_RECOV_EN     <= 1'b1;
        RECOV_DELAY_SEL <= 2'd1;
        OC_DET[0]       <= 1'b1;
        edges(4);
        @(posedge CLK);
        OC_DET[0] <= 1'b0;
        n = 0;
        // delay is base shifted by select: 8 cycles plus sync and output
        while (OUT_EN[0] !== 1'b1) begin
            if (n == 40) timed_out();
            @(negedge CLK);
            n++;
        end
        chk1("recovery delay", 1'b1, n >= 8 && n <= 14);
        rdc(ADDR_OC_LOW, 16'h8000);
        @(posedge CLK);
        OC_RECOV_EN <= 1'b0;
    endtask
    task automatic t_supply;
        @(posedge CLK);
        VS_UV_DET <= 1'b1;
        edges(4);
        @(negedge CLK);
        chk("out_en", 16'h0000, out_w);
        rdc(ADDR_FAULT_HI, 16'h0008);
        rdc(ADDR_FAULT_HI, 16'h0008);
        @(posedge CLK);
        VS_UV_DET <= 1'b0;
        edges(4);
        @(negedge CLK);
        chk("out_en", 16'h07ff, out_w);
        rdc(ADDR_FAULT_HI, 16'h0008);
        rdc(ADDR_FAULT_HI, 16'h0000);
        @(posedge CLK);
        SUPPLY_LATCH <= 1'b1;
        VS_OV_DET    <= 1'b1;
        edges(4);
        @(posedge CLK);
        VS_OV_DET <= 1'b0;
        edges(5);
        @(negedge CLK);
        chk("out_en", 16'h0000, out_w);
        rdc(ADDR_FAULT_HI, 16'h0004);
        edges(3);
        @(negedge CLK);
        chk("out_en", 16'h07ff, out_w);
        @(posedge CLK);
        SUPPLY_LATCH <= 1'b0;
    endtask
    task automatic t_underload;
        int n;
        // high side 1 masked: its undercurrent must not raise a flag
        u_ddsc_host.wr(ADDR_CONFIG, 16'h0020);
        @(posedge CLK);
        ON_REQ[3] <= 1'b0;
        UC_DET    <= 11'h00d;
        n = 0;
        while (GLOBAL_ULD !== 1'b1) begin
            if (n == 1100) timed_out();
            @(negedge CLK);
            n++;
        end
        chk1("uld filter", 1'b1, n >= ULD_FILT_CYC);
        rdc(ADDR_ULD_LOW, 16'h2000);
        @(posedge CLK);
        UC_DET    <= '0;
        ON_REQ[3] <= 1'b1;
        u_ddsc_host.wr(ADDR_CONFIG, 16'h0002);
        @(posedge CLK);
        UC_DET[7] <= 1'b1;
        edges(ULD_FILT_CYC + 10);
        rdc(ADDR_FAULT_HI, 16'h0400);
        chk1("global uld", 1'b0, GLOBAL_ULD);
        @(posedge CLK);
        UC_DET[7] <= 1'b0;
        u_ddsc_host.wr(ADDR_CONFIG, 16'h0000);
        // cause gone now, so this read empties the word for later scenarios
        rdc(ADDR_FAULT_HI, 16'h0400);
        chk1("global uld", 1'b1, GLOBAL_ULD);
    endtask
    task automatic t_mirror;
        @(posedge CLK);
        EC_MODE   <= 1'b1;
        EC_FB_LOW <= 1'b1;
        edges(100);
        rdc(ADDR_FAULT_HI, 16'h0000);
        edges(240);
        rdc(ADDR_FAULT_HI, 16'h0002);
        chk1("fault", 1'b0, GLOBAL_FAULT);
        @(posedge CLK);
        EC_FB_LOW  <= 1'b0;
        EC_FB_HIGH <= 1'b1;
        edges(340);
        rdc(ADDR_FAULT_HI, 16'h0001);
        rdc(ADDR_FAULT_HI, 16'h0001);
        @(posedge CLK);
        EC_FB_HIGH <= 1'b0;
        edges(4);
        rdc(ADDR_FAULT_HI, 16'h0000);
        @(posedge CLK);
        EC_MODE <= 1'b0;
    endtask

    // ****************************************
    // clock and main sequence
    // ****************************************
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    initial begin
        RST = 1'b1;
        ON_REQ = '0;
        OC_DET = '0;
        UC_DET = '0;
        VS_UV_DET = 1'b0;
        VS_OV_DET = 1'b0;
        OC_RECOV_EN = 1'b0;
        RECOV_DELAY_SEL = 2'd0;
        SUPPLY_LATCH = 1'b0;
        EC_MODE = 1'b0;
        EC_FB_LOW = 1'b0;
        EC_FB_HIGH = 1'b0;
        THERM_WARN_DET = 1'b0;
        PWM_BOOST_SEL = 1'b0;
        edges(12);
        RST <= 1'b0;
        t_reset();
        t_config();
        t_overcurrent();
        t_supply();
        t_underload();
        t_mirror();
        end_of_test();
    end
endmodule
